// ### rtl/dual_timer_pkg.sv
// Constants and types for the dual timer block
package dual_timer_pkg;

  localparam int unsigned CLK_MHZ        = 250;
  localparam logic [7:0]  BASE_DIV       = 8'd192;
  localparam logic [7:0]  BASE_DIV_LAST  = BASE_DIV - 8'h01;
  localparam logic [15:0] CNT_RST        = 16'h0000;
  localparam logic [15:0] CNT_TOP        = 16'hffff;
  localparam int unsigned NUM_CH         = 2;

  typedef enum logic [1:0] {
    MODE_MATCH   = 2'b00,
    MODE_COUNT   = 2'b01,
    MODE_CAPTURE = 2'b10
  } chan_mode_t;

  typedef enum logic [1:0] {
    EV_RISE  = 2'b00,
    EV_FALL  = 2'b01,
    EV_BOTH  = 2'b10,
    EV_LEVEL = 2'b11
  } ev_sel_t;

endpackage

// ### rtl/timer_channel.sv
// One programmable timer channel
`timescale 1ns/1ps
module timer_channel (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_tick,
  input  wire logic [15:0] i_base,
  input  wire logic [1:0]  i_mode,
  input  wire logic [1:0]  i_ev_sel,
  input  wire logic [15:0] i_reload_value,
  input  wire logic [15:0] i_ref,
  input  wire logic [15:0] i_ev_target,
  input  wire logic        i_pin_sync,
  output logic             o_pwm,
  output logic             o_irq,
  output logic             o_status,
  output logic [15:0]      o_capture,
  output logic [15:0]      o_count
);

  logic        pin_d_ff;
  logic        nxt_pin_d;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic [15:0] cap_ff;
  logic [15:0] nxt_cap;
  logic        pwm_ff;
  logic        nxt_pwm;
  logic        irq_ff;
  logic        nxt_irq;
  logic        stat_ff;
  logic        nxt_stat;
  logic        rise;
  logic        fall;
  logic        event_hit;

  // ----------------------------------------
  // Event qualification
  // ----------------------------------------
  assign rise = i_pin_sync & ~pin_d_ff;
  assign fall = ~i_pin_sync & pin_d_ff;

  always_comb begin
    unique case (dual_timer_pkg::ev_sel_t'(i_ev_sel))
      dual_timer_pkg::EV_RISE:  event_hit = rise;
      dual_timer_pkg::EV_FALL:  event_hit = fall;
      dual_timer_pkg::EV_BOTH:  event_hit = rise | fall;
      // Level change: any toggle, same as both edges on a sampled pin
      dual_timer_pkg::EV_LEVEL: event_hit = i_pin_sync ^ pin_d_ff;
    endcase
  end

  // ----------------------------------------
  // Mode logic
  // ----------------------------------------
  always_comb begin
    nxt_pin_d = i_pin_sync;
    nxt_cnt   = cnt_ff;
    nxt_cap   = cap_ff;
    nxt_pwm   = pwm_ff;
    nxt_irq   = 1'b0;
    nxt_stat  = stat_ff;
    unique case (i_mode)
      dual_timer_pkg::MODE_MATCH: begin
        if (i_tick) begin
          // Count left below the window by another mode restarts a period
          if (cnt_ff == dual_timer_pkg::CNT_TOP ||
              cnt_ff <= i_reload_value) begin
            // Window reload+1..FFFF gives FFFF-reload ticks
            nxt_cnt  = i_reload_value + 16'h0001;
            nxt_pwm  = 1'b1;
            nxt_irq  = 1'b1;
            nxt_stat = 1'b1;
          end else begin
            nxt_cnt = cnt_ff + 16'h0001;
            // Active part lasts ref ticks of period FFFF-reload
            if (cnt_ff - i_reload_value == i_ref) begin
              nxt_pwm  = 1'b0;
              nxt_irq  = 1'b1;
              nxt_stat = 1'b1;
            end
          end
        end
      end
      dual_timer_pkg::MODE_COUNT: begin
        if (event_hit) begin
          nxt_cnt = cnt_ff + 16'h0001;
          if (cnt_ff + 16'h0001 == i_ev_target) begin
            nxt_cnt  = dual_timer_pkg::CNT_RST;
            nxt_irq  = 1'b1;
            nxt_stat = 1'b1;
          end
        end
        nxt_pwm = 1'b0;
      end
      dual_timer_pkg::MODE_CAPTURE: begin
        if (event_hit) begin
          nxt_cap  = i_base;
          nxt_irq  = 1'b1;
          nxt_stat = 1'b1;
        end
        nxt_pwm = 1'b0;
      end
      default: begin
        nxt_pwm = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pin_d_ff <= 1'b0;
      cnt_ff   <= dual_timer_pkg::CNT_RST;
      cap_ff   <= dual_timer_pkg::CNT_RST;
      pwm_ff   <= 1'b0;
      irq_ff   <= 1'b0;
      stat_ff  <= 1'b0;
    end else begin
      pin_d_ff <= nxt_pin_d;
      cnt_ff   <= nxt_cnt;
      cap_ff   <= nxt_cap;
      pwm_ff   <= nxt_pwm;
      irq_ff   <= nxt_irq;
      stat_ff  <= nxt_stat;
    end
  end

  assign o_pwm     = pwm_ff;
  assign o_irq     = irq_ff;
  assign o_status  = stat_ff;
  assign o_capture = cap_ff;
  assign o_count   = cnt_ff;

endmodule

// ### rtl/dual_timer_with_free_run_base.sv
// Top of the dual timer with free-running base counter
// What this block does
// - Base counter steps every 192 clocks
// - Two independent 16-bit programmable channels
// - Match mode drives channel output pin
// - Period FFFF minus reload, duty from reference
// - Rollover and match raise interrupt, status
// - Event count reaching target raises interrupt
// - Event selects rise, fall, both, level
// - Capture copies base count, flags, interrupts
`timescale 1ns/1ps
module dual_timer_with_free_run_base (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_channel_one_pin,
  input  wire logic        i_channel_two_pin,
  input  wire logic [1:0]  i_mode_one,
  input  wire logic [1:0]  i_mode_two,
  input  wire logic [1:0]  i_ev_sel_one,
  input  wire logic [1:0]  i_ev_sel_two,
  input  wire logic [15:0] i_reload_value_one,
  input  wire logic [15:0] i_reload_value_two,
  input  wire logic [15:0] i_ref_one,
  input  wire logic [15:0] i_ref_two,
  input  wire logic [15:0] i_ev_target_one,
  input  wire logic [15:0] i_ev_target_two,
  input  wire logic        i_status_clr_one,
  input  wire logic        i_status_clr_two,
  output logic             o_channel_one_out,
  output logic             o_channel_two_out,
  output logic [1:0]       o_irq,
  output logic [1:0]       o_status,
  output logic [15:0]      o_base,
  output logic [15:0]      o_capture_one,
  output logic [15:0]      o_capture_two,
  output logic [15:0]      o_count_one,
  output logic [15:0]      o_count_two
);

  logic [7:0]  div_ff;
  logic [7:0]  nxt_div;
  logic [15:0] base_ff;
  logic [15:0] nxt_base;
  logic        tick;
  logic [1:0]  pin_s1_ff;
  logic [1:0]  pin_s2_ff;
  logic [1:0]  stat_ff;
  logic [1:0]  nxt_stat;
  logic [1:0]  ch_pwm;
  logic [1:0]  ch_irq;
  logic [1:0]  ch_stat;
  logic [15:0] ch_cap   [2];
  logic [15:0] ch_cnt   [2];
  logic [1:0]  mode     [2];
  logic [1:0]  ev_sel   [2];
  logic [15:0] reload   [2];
  logic [15:0] refv     [2];
  logic [15:0] target   [2];
  logic [1:0]  clr;

  // ----------------------------------------
  // Free-running base
  // ----------------------------------------
  assign tick = (div_ff == dual_timer_pkg::BASE_DIV_LAST);

  always_comb begin
    nxt_div  = tick ? 8'h00 : div_ff + 8'h01;
    nxt_base = tick ? base_ff + 16'h0001 : base_ff;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      div_ff  <= 8'h00;
      base_ff <= dual_timer_pkg::CNT_RST;
    end else begin
      div_ff  <= nxt_div;
      base_ff <= nxt_base;
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pin_s1_ff <= 2'b00;
      pin_s2_ff <= 2'b00;
    end else begin
      pin_s1_ff <= {i_channel_two_pin, i_channel_one_pin};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  assign mode   = '{i_mode_one, i_mode_two};
  assign ev_sel = '{i_ev_sel_one, i_ev_sel_two};
  assign reload = '{i_reload_value_one, i_reload_value_two};
  assign refv   = '{i_ref_one, i_ref_two};
  assign target = '{i_ev_target_one, i_ev_target_two};
  assign clr    = {i_status_clr_two, i_status_clr_one};

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  for (genvar g = 0; g < dual_timer_pkg::NUM_CH; g++) begin : g_ch
    timer_channel u_ch (
      .i_clk          (i_clk),
      .i_srst         (i_srst),
      .i_tick         (tick),
      .i_base         (base_ff),
      .i_mode         (mode[g]),
      .i_ev_sel       (ev_sel[g]),
      .i_reload_value (reload[g]),
      .i_ref          (refv[g]),
      .i_ev_target    (target[g]),
      .i_pin_sync     (pin_s2_ff[g]),
      .o_pwm          (ch_pwm[g]),
      .o_irq          (ch_irq[g]),
      .o_status       (ch_stat[g]),
      .o_capture      (ch_cap[g]),
      .o_count        (ch_cnt[g])
    );
  end

  // ----------------------------------------
  // Sticky status; set wins over clear
  // ----------------------------------------
  always_comb begin
    nxt_stat = (stat_ff & ~clr) | ch_irq;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      stat_ff <= 2'b00;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  assign o_channel_one_out = ch_pwm[0];
  assign o_channel_two_out = ch_pwm[1];
  assign o_irq             = ch_irq;
  assign o_status          = stat_ff;
  assign o_base            = base_ff;
  assign o_capture_one     = ch_cap[0];
  assign o_capture_two     = ch_cap[1];
  assign o_count_one       = ch_cnt[0];
  assign o_count_two       = ch_cnt[1];

endmodule

// ### tb/dual_timer_with_free_run_base_properties.sv
// Port assertions for the dual timer block
`timescale 1ns/1ps
module dual_timer_with_free_run_base_properties (
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic [1:0]  i_mode_one,
  input wire logic [1:0]  i_mode_two,
  input wire logic [15:0] i_ev_target_two,
  input wire logic        o_channel_one_out,
  input wire logic [1:0]  o_irq,
  input wire logic [1:0]  o_status,
  input wire logic [15:0] o_base,
  input wire logic [15:0] o_capture_one,
  input wire logic [15:0] o_count_two
);
  // ----
  // Base step spacing
  // ----
  logic [15:0] prev_ff;
  logic [15:0] nxt_prev;
  logic [7:0]  gap_ff;
  logic [7:0]  nxt_gap;
  logic        seen_ff;
  logic        nxt_seen;
  // First step after reset is skipped: its spacing depends on release
  always_comb begin
    nxt_prev = i_srst ? 16'h0000 : o_base;
    nxt_gap  = (i_srst || o_base != prev_ff) ? 8'h00 : gap_ff + 8'h01;
    nxt_seen = !i_srst && (seen_ff || o_base != prev_ff);
  end
  always_ff @(posedge i_clk) begin
    prev_ff <= nxt_prev;
    gap_ff  <= nxt_gap;
    seen_ff <= nxt_seen;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  chk_base_step: assert property (
    o_base != prev_ff |-> o_base == prev_ff + 16'h0001)
    else $error("base jumped");
  chk_base_gap: assert property (
    o_base != prev_ff && seen_ff |-> gap_ff == 8'hbf)
    else $error("base spacing wrong");
  chk_base_alive: assert property (gap_ff < 8'hc8)
    else $error("base stalled");
  chk_status_one: assert property (
    o_irq[0] && i_mode_one != dual_timer_pkg::MODE_COUNT |=> o_status[0])
    else $error("status one not set");
  chk_status_two: assert property (
    o_irq[1] |=> o_status[1])
    else $error("status two not set");
  chk_capture_irq: assert property ($changed(o_capture_one) |-> o_irq[0]
    && (o_capture_one == o_base || o_capture_one == $past(o_base)))
    else $error("capture without base or irq");
  chk_idle_quiet: assert property (
    i_mode_one == 2'b11 [*2] |-> !o_channel_one_out)
    else $error("output driven in idle");
  chk_count_bound: assert property (
    i_mode_two == dual_timer_pkg::MODE_COUNT [*2]
    |-> o_count_two <= i_ev_target_two)
    else $error("count passed target");
  chk_rise_irq: assert property (
    $rose(o_channel_one_out) |-> o_irq[0])
    else $error("reload without irq");
  cov_capture: cover property ($changed(o_capture_one));
  cov_count_irq: cover property (o_irq[1]);
  cov_idle: cover property (i_mode_one == 2'b11 [*2]);
  cov_match: cover property ($rose(o_channel_one_out));
endmodule

// ### tb/event_source.sv
// Behavioural source of the two channel event pins
`timescale 1ns/1ps
module event_source #(
  parameter time DLY = 1.3
) (
  input  wire logic [1:0] i_level,
  output logic      [1:0] o_pin
);
  // Lags the request, so pin edges never sit on a rising clock edge
  initial o_pin = 2'b00;
  always @(i_level) o_pin <= #DLY i_level;
endmodule

// ### tb/dual_timer_with_free_run_base_bench.sv
// Self-checking bench for the dual timer block
`timescale 1ns/1ps
module dual_timer_with_free_run_base_bench;
  logic        i_clk, i_srst, o1, seen;
  logic [1:0]  lvl, pin, m1, m2, sel, clr, irq, st;
  logic [15:0] tgt2, exp, base, cap1, cnt2;
  int          failures, checks, i, n;
  // ----
  // Harness
  // ----
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  event_source src_u (.i_level(lvl), .o_pin(pin));
  dual_timer_with_free_run_base dut_u (.i_clk(i_clk), .i_srst(i_srst),
    .i_channel_one_pin(pin[0]), .i_channel_two_pin(pin[1]),
    .i_mode_one(m1), .i_mode_two(m2), .i_ev_sel_one(sel),
    .i_ev_sel_two(sel), .i_reload_value_one(16'hfff0),
    .i_reload_value_two(16'hfff0), .i_ref_one(16'h0004),
    .i_ref_two(16'h0004), .i_ev_target_one(16'h0010),
    .i_ev_target_two(tgt2), .i_status_clr_one(clr[0]),
    .i_status_clr_two(clr[1]), .o_channel_one_out(o1),
    .o_channel_two_out(), .o_irq(irq), .o_status(st), .o_base(base),
    .o_capture_one(cap1), .o_capture_two(), .o_count_one(),
    .o_count_two(cnt2));
  task automatic check(string n, logic [15:0] got, logic [15:0] want);
    checks++;
    if (got !== want) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, want, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Cycles until channel one output reads v; capped so a stall fails
  task automatic span(logic v);
    n = 0;
    while (o1 !== v && n < 4000) begin
      tick(1);
      n++;
    end
  endtask
  // Six cycles cover partner lag, two sync flops and edge detect
  task automatic drive(logic [1:0] v);
    lvl = v;
    tick(6);
  endtask
  initial begin
    #80000;
    failures++;
    wrap_up();
  end
  initial begin
    i_srst = 1'b1; lvl = 2'b00; m1 = 2'b10; m2 = 2'b01; sel = 2'b00;
    clr = 2'b00; tgt2 = 16'hffff; exp = 16'h0000; failures = 0; checks = 0;
    tick(20);
    i_srst = 1'b0;
    tick(200);
    check("base", base, 16'h0001);
    drive(2'b01);
    check("capture", cap1, 16'h0001);
    check("status", {15'h0000, st[0]}, 16'h0001);
    clr = 2'b01;
    tick(1);
    clr = 2'b00;
    tick(1);
    check("status", {15'h0000, st[0]}, 16'h0000);
    tick(184);
    check("base", base, 16'h0002);
    for (i = 0; i < 4; i++) begin
      sel = i[1:0];
      drive(2'b11);
      exp = exp + {15'h0000, i != 1};
      drive(2'b01);
      exp = exp + {15'h0000, i != 0};
      check("count", cnt2, exp);
    end
    tgt2 = exp + 16'h0002;
    sel = 2'b00;
    drive(2'b11);
    drive(2'b01);
    lvl = 2'b11;
    seen = 1'b0;
    repeat (8) begin
      tick(1);
      seen = seen | irq[1];
    end
    check("count irq", {15'h0000, seen}, 16'h0001);
    check("count", cnt2, 16'h0000);
    m1 = 2'b11;
    tick(3);
    check("idle out", {15'h0000, o1}, 16'h0000);
    m1 = 2'b00;
    span(1'b1);
    span(1'b0);
    check("high time", n[15:0], 16'h0300);
    span(1'b1);
    check("low time", n[15:0], 16'h0840);
    check("status", {15'h0000, st[0]}, 16'h0001);
    i_srst = 1'b1;
    tick(2);
    check("base", base, 16'h0000);
    i_srst = 1'b0;
    tick(2);
    wrap_up();
  end
endmodule
bind dual_timer_with_free_run_base dual_timer_with_free_run_base_properties
  chk_u (.i_clk(i_clk), .i_srst(i_srst), .i_mode_one(i_mode_one),
  .i_mode_two(i_mode_two), .i_ev_target_two(i_ev_target_two),
  .o_channel_one_out(o_channel_one_out), .o_irq(o_irq),
  .o_status(o_status), .o_base(o_base), .o_capture_one(o_capture_one),
  .o_count_two(o_count_two));
